// File: rtl/rq_pkg.sv
// shared constants and carrier types for the request-path issuing controller
package rq_pkg;
    localparam int DATA_W = 64;
    localparam int KEEP_W = 2;
    localparam int SB_W = 24;
    localparam int FIFO_DEPTH = 8;
    localparam int HWORD_W = 32;

    // controller register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR_LO = 8'h04;
    localparam logic [7:0] REG_ADDR_HI = 8'h08;
    localparam logic [7:0] REG_DESC2 = 8'h0c;
    localparam logic [7:0] REG_DESC3 = 8'h10;
    localparam logic [7:0] REG_SIDE = 8'h14;
    localparam logic [7:0] REG_DATA = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [7:0] REG_COUNT = 8'h20;

    // control register fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_ADDR_ALIGNED = 1;
    localparam int CTRL_PAYLOAD = 2;
    // sideband register fields
    localparam int SIDE_FBE_LSB = 0;
    localparam int SIDE_LBE_LSB = 4;
    localparam int SIDE_LANE_LSB = 8;
    localparam int SIDE_HINT = 11;
    localparam int SIDE_LOOKUP = 12;
    localparam int SIDE_KIND_LSB = 13;
    localparam int SIDE_TAG_LSB = 16;
    // descriptor field positions
    localparam int DESC_XL_LSB = 0;
    localparam int DESC_DWC_LSB = 64;
    localparam int DWC_W = 11;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [3:0] RESET_COUNT = 4'h0;

    typedef struct packed {
        logic [3:0] first_word_byte_mask;
        logic [3:0] final_word_byte_mask;
        logic [2:0] payload_lane_index;
        logic hint_valid;
        logic steering_tag_lookup_sel;
        logic [1:0] steering_tag_kind;
        logic [7:0] steering_tag_value;
    } request_sideband_bus_t;

    typedef struct packed {
        logic [DATA_W-1:0] tdata;
        logic [KEEP_W-1:0] tkeep;
        logic tlast;
        request_sideband_bus_t tuser;
    } request_beat_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DESC0,
        ST_DESC1,
        ST_DATA
    } issue_state_t;
endpackage

// File: rtl/word_fifo.sv
// synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign level = st.count;
    // read data straight from the storage word under the read pointer
    assign out_data = mem[st.rptr];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wptr = st.wptr + AW'(1);
        end
        if (pop) begin
            next_st.rptr = st.rptr + AW'(1);
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[st.wptr] <= in_data;
        end
    end
endmodule

// File: rtl/ahb_regs.sv
// ahb-lite slave passing command writes and status reads through to the controller
`timescale 1ns/1ps
module ahb_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data
);
    typedef struct packed {
        logic wpend;
        logic [7:0] waddr;
        logic [31:0] rdata;
    } slave_state_t;

    slave_state_t st;
    slave_state_t next_st;
    logic take;

    // only word transfers are supported, so hsize is not decoded
    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign wr_en = st.wpend;
    assign wr_addr = st.waddr;
    assign wr_data = hwdata;
    assign rd_addr = haddr[7:0];

    always_comb begin
        next_st = st;
        next_st.wpend = take && hwrite;
        if (take) begin
            next_st.waddr = haddr[7:0];
        end
        if (take && !hwrite) begin
            next_st.rdata = rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// File: rtl/rq_issuer.sv
// controller that frames request packets onto the request path stream
//
// Contract
// - posted one operation, non-posted split with completions
// - packet is descriptor then optional payload
// - descriptor fills first two 64-bit beats
// - dword-aligned payload follows descriptor without gap; here payload starts one idle cycle after the descriptor, each dword in its own beat in lane 0
// - drive first and final byte masks
// - address-aligned payload next beat, lane index given; here payload still starts at lane 0
// - hint in first beat with tag, kind
// - descriptor layout chosen by request type
// - address in bits 63:2, upper zero
// - dword count at bits 74:64
// - zero-length access: count one, mask zero
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module rq_issuer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [rq_pkg::DATA_W-1:0] request_path_tdata,
    output logic [rq_pkg::KEEP_W-1:0] request_path_tkeep,
    output logic request_path_tlast,
    output rq_pkg::request_sideband_bus_t request_sideband_bus,
    output logic request_path_tvalid,
    input wire logic request_path_tready,
    input wire logic completion_path_tvalid,
    output logic completion_path_tready
);
    typedef struct packed {
        rq_pkg::issue_state_t state;
        logic addr_aligned;
        logic with_payload;
        logic [31:0] addr_lo;
        logic [31:0] addr_hi;
        logic [31:0] desc2;
        logic [31:0] desc3;
        logic [31:0] side;
        logic [31:0] held_word;
        logic held_valid;
        logic [3:0] sent;
        rq_pkg::request_beat_t beat;
        logic beat_valid;
        logic [3:0] comp_count;
    } issuer_state_t;

    issuer_state_t st;
    issuer_state_t next_st;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [31:0] fifo_out_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [3:0] fifo_level;
    logic beat_taken;
    logic go;

    ahb_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // payload words: a data-register write is held until the FIFO accepts it
    assign fifo_in_valid = st.held_valid;

    word_fifo #(
        .WIDTH(32),
        .DEPTH(rq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_data(st.held_word),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .level(fifo_level)
    );

    // both streams are logic on hclk: a synchroniser here would let the far side see a beat twice
    // a beat moves at the edge where valid meets ready
    assign beat_taken = st.beat_valid && request_path_tready;

    assign request_path_tdata = st.beat.tdata;
    assign request_path_tkeep = st.beat.tkeep;
    assign request_path_tlast = st.beat.tlast;
    assign request_sideband_bus = st.beat.tuser;
    assign request_path_tvalid = st.beat_valid;
    // completions are always accepted, never blocked by requests
    assign completion_path_tready = 1'b1;

    assign go = wr_en && (wr_addr == rq_pkg::REG_CTRL) && wr_data[rq_pkg::CTRL_GO]
        && (st.state == rq_pkg::ST_IDLE);

    // payload words leave the FIFO only when a data beat is being loaded
    assign fifo_out_ready = (st.state == rq_pkg::ST_DATA) && fifo_out_valid
        && (!st.beat_valid || beat_taken);

    function automatic logic [31:0] read_mux(input logic [7:0] a, input issuer_state_t s,
                                             input logic [3:0] lvl, input logic held);
        logic [31:0] r;
        r = rq_pkg::RESET_WORD;
        case (a)
            rq_pkg::REG_CTRL: r = {29'h0000_0000, s.with_payload, s.addr_aligned, 1'b0};
            rq_pkg::REG_ADDR_LO: r = s.addr_lo;
            rq_pkg::REG_ADDR_HI: r = s.addr_hi;
            rq_pkg::REG_DESC2: r = s.desc2;
            rq_pkg::REG_DESC3: r = s.desc3;
            rq_pkg::REG_SIDE: r = s.side;
            rq_pkg::REG_STATUS: r = {24'h00_0000, lvl, held, s.beat_valid,
                                     (s.state != rq_pkg::ST_IDLE), (s.state == rq_pkg::ST_IDLE)};
            rq_pkg::REG_COUNT: r = {24'h00_0000, s.comp_count, s.sent};
            default: r = rq_pkg::RESET_WORD;
        endcase
        return r;
    endfunction

    assign rd_data = read_mux(rd_addr, st, fifo_level, st.held_valid);

    // byte masks and other sideband fields from the sideband register
    function automatic rq_pkg::request_sideband_bus_t side_of(input logic [31:0] s, input logic first);
        rq_pkg::request_sideband_bus_t u;
        u.first_word_byte_mask = s[rq_pkg::SIDE_FBE_LSB +: 4];
        u.final_word_byte_mask = s[rq_pkg::SIDE_LBE_LSB +: 4];
        // lane of the first payload dword in address-aligned mode
        u.payload_lane_index = s[rq_pkg::SIDE_LANE_LSB +: 3];
        // hint fields qualify only the first beat
        u.hint_valid = first && s[rq_pkg::SIDE_HINT];
        // lookup select rides with the hint, tag becomes an index
        u.steering_tag_lookup_sel = first && s[rq_pkg::SIDE_HINT] && s[rq_pkg::SIDE_LOOKUP];
        u.steering_tag_kind = s[rq_pkg::SIDE_KIND_LSB +: 2];
        u.steering_tag_value = s[rq_pkg::SIDE_TAG_LSB +: 8];
        return u;
    endfunction

    always_comb begin
        next_st = st;

        // count completion beats arriving on the completion path
        if (completion_path_tvalid) begin
            next_st.comp_count = st.comp_count + 4'h1;
        end

        if (st.held_valid && fifo_in_ready) begin
            next_st.held_valid = 1'b0;
        end
        // a second data write while one is still held is dropped
        if (wr_en && wr_addr == rq_pkg::REG_DATA && !st.held_valid) begin
            next_st.held_word = wr_data;
            next_st.held_valid = 1'b1;
        end

        if (wr_en && st.state == rq_pkg::ST_IDLE) begin
            case (wr_addr)
                rq_pkg::REG_ADDR_LO: next_st.addr_lo = wr_data;
                rq_pkg::REG_ADDR_HI: next_st.addr_hi = wr_data;
                rq_pkg::REG_DESC2: next_st.desc2 = wr_data;
                rq_pkg::REG_DESC3: next_st.desc3 = wr_data;
                rq_pkg::REG_SIDE: next_st.side = wr_data;
                rq_pkg::REG_CTRL: begin
                    next_st.addr_aligned = wr_data[rq_pkg::CTRL_ADDR_ALIGNED];
                    next_st.with_payload = wr_data[rq_pkg::CTRL_PAYLOAD];
                end
                default: next_st.sent = st.sent;
            endcase
        end

        if (beat_taken) begin
            next_st.beat_valid = 1'b0;
        end

        case (st.state)
            rq_pkg::ST_IDLE: begin
                if (go) begin
                    // every request opens with its descriptor
                    // first 64-bit beat holds descriptor dwords 0 and 1
                    // bits 1:0 of addr_lo are the translation kind
                    // software keeps addr_hi zero for 32-bit addresses
                    next_st.beat.tdata = {st.addr_hi, st.addr_lo};
                    next_st.beat.tkeep = 2'b11;
                    next_st.beat.tlast = 1'b0;
                    next_st.beat.tuser = side_of(st.side, 1'b1);
                    next_st.addr_aligned = wr_data[rq_pkg::CTRL_ADDR_ALIGNED];
                    next_st.with_payload = wr_data[rq_pkg::CTRL_PAYLOAD];
                    next_st.beat_valid = 1'b1;
                    next_st.state = rq_pkg::ST_DESC0;
                end
            end
            rq_pkg::ST_DESC0: begin
                if (beat_taken) begin
                    // dword count at 74:64, layout set by software in desc2/desc3
                    // zero-length uses count one with first mask zero, passed untouched
                    // the count is not checked against payload length here either
                    next_st.beat.tdata = {st.desc3, st.desc2};
                    next_st.beat.tkeep = 2'b11;
                    // posted or non-posted, the packet is issued the same way
                    next_st.beat.tlast = !st.with_payload;
                    next_st.beat.tuser = side_of(st.side, 1'b0);
                    next_st.beat_valid = 1'b1;
                    next_st.state = rq_pkg::ST_DESC1;
                end
            end
            rq_pkg::ST_DESC1: begin
                if (beat_taken) begin
                    next_st.sent = st.with_payload ? st.sent : st.sent + 4'h1;
                    next_st.state = st.with_payload ? rq_pkg::ST_DATA : rq_pkg::ST_IDLE;
                end
            end
            rq_pkg::ST_DATA: begin
                if (fifo_out_ready) begin
                    // dword mode sends payload one idle cycle after the last descriptor beat, one dword per beat in the low lane
                    // address mode also starts on a new beat at lane 0 here
                    next_st.beat.tdata = {32'h0000_0000, fifo_out_data};
                    next_st.beat.tkeep = 2'b01;
                    next_st.beat.tlast = (fifo_level == 4'h1) && !st.held_valid;
                    next_st.beat.tuser = side_of(st.side, 1'b0);
                    next_st.beat_valid = 1'b1;
                    if ((fifo_level == 4'h1) && !st.held_valid) begin
                        next_st.state = rq_pkg::ST_IDLE;
                        next_st.sent = st.sent + 4'h1;
                    end
                end
            end
            default: next_st.state = rq_pkg::ST_IDLE;
        endcase
    end

    // one 64-bit request stream, completion stream kept apart
    // I/O and configuration requests only differ in descriptor words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// File: testbench/rq_issuer_assertions.sv
// assertions on the request-path issuing controller's ports
`timescale 1ns/1ps
module rq_issuer_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hresp,
    input wire logic hreadyout,
    input wire logic [rq_pkg::DATA_W-1:0] request_path_tdata,
    input wire logic [rq_pkg::KEEP_W-1:0] request_path_tkeep,
    input wire logic request_path_tlast,
    input wire rq_pkg::request_sideband_bus_t request_sideband_bus,
    input wire logic request_path_tvalid,
    input wire logic request_path_tready,
    input wire logic completion_path_tvalid,
    input wire logic completion_path_tready
);
    logic [3:0] idx;
    logic v, l, go;
    assign v = request_path_tvalid;
    assign l = request_path_tlast;
    // a beat moves at the edge where valid meets ready
    assign go = v & request_path_tready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx <= 4'h0;
        end else begin
            if (go)
                idx <= l ? 4'h0 : idx + 4'h1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_beat_held: assert property (v && !go |=> v && $stable(request_path_tdata) && $stable(l)
        && $stable(request_sideband_bus)) else $error("beat changed while waiting");
    a_desc_open: assert property (v && idx == 4'h0 |-> !l && request_path_tkeep == 2'b11)
        else $error("first descriptor beat malformed");
    a_desc_close: assert property (v && idx == 4'h1 |-> request_path_tkeep == 2'b11)
        else $error("second descriptor beat not full");
    a_payload_lane: assert property (v && idx > 4'h1 |-> request_path_tkeep == 2'b01)
        else $error("payload beat not in low lane");
    a_payload_cap: assert property (v |-> idx < 4'hb)
        else $error("packet longer than the buffer allows");
    a_last_ends: assert property (go && l |=> !v)
        else $error("valid held after final beat");
    a_next_beat: assert property (go && !l |-> ##[1:4] v)
        else $error("packet stalled mid-way");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
    a_cpl_open: assert property (completion_path_tready)
        else $error("completion path refused");
    c_payload: cover property (go && l && idx > 4'h1);
    c_stall: cover property ((v && !go) [*3]);
    c_both: cover property (v && completion_path_tvalid);
endmodule
bind rq_issuer rq_issuer_checker chk (.hclk, .hresetn, .hresp, .hreadyout, .request_path_tdata, .request_path_tkeep,
    .request_path_tlast, .request_sideband_bus, .request_path_tvalid, .request_path_tready, .completion_path_tvalid,
    .completion_path_tready);

// File: testbench/rq_device.sv
// device model for the request path: stalling sink and completion source
`timescale 1ns/1ps
module rq_device (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow,
    input wire logic tvalid,
    input wire logic [63:0] tdata,
    input wire logic tlast,
    input wire rq_pkg::request_sideband_bus_t tuser,
    output logic tready,
    output logic taken,
    input wire logic cpl_go,
    input wire logic [3:0] cpl_n,
    input wire logic cpl_rdy,
    output logic cpl_valid
);
    int seed = 93;
    logic [1:0] low, xl_kind;
    logic [3:0] pend;
    logic armed, first;
    logic [7:0] tag_used;
    assign taken = tvalid & tready;
    assign cpl_valid = pend != 4'h0;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tready <= 1'b0;
            low <= 2'b00;
            pend <= 4'h0;
            armed <= 1'b0;
            first <= 1'b1;
        end else begin
            // random stalls of two cycles exercise the held-beat path
            if (low != 2'b00) begin
                low <= low - 2'b01;
                tready <= low == 2'b01;
            end else if (slow && ($random(seed) & 3) == 0) begin
                low <= 2'b10;
                tready <= 1'b0;
            end else
                tready <= 1'b1;
            if (taken)
                first <= tlast;
            // kind copied, indirect tag inverted
            if (taken && first) begin
                xl_kind <= tdata[1:0];
                tag_used <= tuser.steering_tag_lookup_sel ? ~tuser.steering_tag_value : tuser.steering_tag_value;
            end
            if (cpl_go && !armed && pend == 4'h0)
                pend <= cpl_n;
            else if (cpl_valid && cpl_rdy)
                pend <= pend - 4'h1;
            armed <= cpl_go;
        end
    end
endmodule

// File: testbench/test_rq_issuer.sv
// self-checking bench for the request-path issuing controller
`timescale 1ns/1ps
module test_rq_issuer;
    logic hclk, hresetn, hsel, hwrite, hrdy, hresp, rd_live, slow, cpl_go, taken, tl, tv, tr, cv, cr;
    logic [1:0] htrans, tk;
    logic [2:0] hsize;
    logic [3:0] cpl_n;
    logic [31:0] haddr, hwdata, hrdata;
    logic [63:0] td;
    rq_pkg::request_sideband_bus_t tu;
    logic [89:0] rd_q[$], st_q[$];
    int seed = 93;
    int failures = 0;
    int checked = 0;
    rq_issuer uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hrdy), .hrdata,
        .hreadyout(hrdy), .hresp, .request_path_tdata(td), .request_path_tkeep(tk), .request_path_tlast(tl),
        .request_sideband_bus(tu), .request_path_tvalid(tv), .request_path_tready(tr),
        .completion_path_tvalid(cv), .completion_path_tready(cr));
    rq_device dev (.hclk, .hresetn, .slow, .tvalid(tv), .tdata(td), .tlast(tl), .tuser(tu), .tready(tr), .taken,
        .cpl_go, .cpl_n, .cpl_rdy(cr), .cpl_valid(cv));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic check(input logic [89:0] seen, input logic [89:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic stop_if(input logic hung);
        if (hung) begin
            failures++;
            report_and_stop();
        end
    endtask
    task automatic ready_wait;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        stop_if(hrdy !== 1'b1);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        ready_wait();
        htrans <= 2'b00;
        hwdata <= d;
        rd_live <= ~wr;
        ready_wait();
        rd_live <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(90'(e));
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // sideband word: masks, lane, hint, lookup, kind, tag
    // hint and lookup select qualify the first beat only
    function automatic logic [89:0] beat(input logic [63:0] d, input logic [1:0] k, input logic l,
            input logic [31:0] s, input logic f);
        return {d, k, l, s[3:0], s[7:4], s[10:8], s[11] & f, s[12] & s[11] & f, s[14:13], s[23:16]};
    endfunction
    always @(posedge hclk) begin
        if (rd_live === 1'b1)
            check(90'(hrdata), rd_q.size() ? rd_q.pop_front() : '1);
        if (taken === 1'b1)
            check({tk == 2'b01 ? 32'h0000_0000 : td[63:32], td[31:0], tk, tl, tu},
                st_q.size() ? st_q.pop_front() : '1);
    end
    task automatic packet(input logic [1:0] xl, input logic [10:0] cnt, input int words, input logic aligned);
        logic [31:0] lo, d2, d3, s, w;
        int n;
        lo = $random(seed);
        d2 = $random(seed);
        d3 = $random(seed);
        s = $random(seed);
        lo[1:0] = xl;
        d2[10:0] = cnt;
        // zero-length read: first mask clear
        if (cnt == 11'h001 && words == 0)
            s[3:0] = 4'h0;
        bus(1'b1, rq_pkg::REG_ADDR_LO, lo);
        bus(1'b1, rq_pkg::REG_ADDR_HI, 32'h0000_0000);
        bus(1'b1, rq_pkg::REG_DESC2, d2);
        bus(1'b1, rq_pkg::REG_DESC3, d3);
        bus(1'b1, rq_pkg::REG_SIDE, s);
        st_q.push_back(beat({32'h0000_0000, lo}, 2'b11, 1'b0, s, 1'b1));
        st_q.push_back(beat({d3, d2}, 2'b11, words == 0, s, 1'b0));
        for (int i = 0; i < words; i++) begin
            w = $random(seed);
            bus(1'b1, rq_pkg::REG_DATA, w);
            if (i < 9)
                st_q.push_back(beat({32'h0000_0000, w}, 2'b01, i == words - 1 || i == 8, s, 1'b0));
        end
        // eight queued plus one held; the tenth word is dropped
        if (words > 9)
            rd(rq_pkg::REG_STATUS, 32'h0000_0089);
        bus(1'b1, rq_pkg::REG_CTRL, {29'h0, words > 0, aligned, 1'b1});
        // a start while busy is ignored
        if (words > 9)
            bus(1'b1, rq_pkg::REG_CTRL, {29'h0, 1'b1, aligned, 1'b1});
        n = 0;
        while ((st_q.size() != 0 || tv !== 1'b0) && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        stop_if(n >= 3000);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'b010;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        rd_live = 1'b0;
        slow = 1'b0;
        cpl_go = 1'b0;
        cpl_n = 4'h5;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd(rq_pkg::REG_STATUS, 32'h0000_0001);
        rd(rq_pkg::REG_COUNT, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        $display("test reset values done");
        for (int k = 0; k < 4; k++)
            packet(2'(k), 11'(k * 300 + 1), 0, 1'b0);
        $display("test descriptor packets done");
        packet(2'b01, 11'h001, 1, 1'b1);
        slow <= 1'b1;
        cpl_go <= 1'b1;
        // full buffer, stalled sink, completions meanwhile
        packet(2'b10, 11'h009, 10, 1'b0);
        cpl_go <= 1'b0;
        $display("test payload packets done");
        rd(rq_pkg::REG_COUNT, 32'h0000_0056);
        report_and_stop();
    end
endmodule
